// >>> tov_defs.vh
// Constants for the overflow timer block
`ifndef TOV_DEFS_VH
`define TOV_DEFS_VH
`define TOV_ADDR_W          4
`define TOV_REG_CTRL        4'h0
`define TOV_REG_CNT_LO      4'h1
`define TOV_REG_CNT_HI      4'h2
`define TOV_REG_FLAGS       4'h3
`define TOV_REG_ENABLES     4'h4
`define TOV_REG_OSC_CTRL    4'h5
`define TOV_REG_CMP1_LO     4'h6
`define TOV_REG_CMP1_HI     4'h7
`define TOV_REG_CMP2_LO     4'h8
`define TOV_REG_CMP2_HI     4'h9
`define TOV_REG_CMP_MODE    4'ha
`define TOV_REG_ADC_CTRL    4'hb
`define TOV_CTRL_ON         0
`define TOV_CTRL_SRC        1
`define TOV_CTRL_BYP        2
`define TOV_CTRL_OSCEN      3
`define TOV_CTRL_PS_LO      4
`define TOV_CTRL_PS_HI      5
`define TOV_CTRL_RUN        6
`define TOV_CTRL_WIDE       7
`define TOV_OSC_SCS_LO      0
`define TOV_OSC_SCS_HI      1
`define TOV_OSC_IDLE        7
`define TOV_SCS_SECONDARY   2'h1
`define TOV_CMP_TRIG_MODE   4'hb
`define TOV_FLAG_OVF        0
`define TOV_EN_OVF          0
`define TOV_ADC_EN          0
`define TOV_CNT_MAX         16'hffff
`define TOV_CNT_ZERO        16'h0000
`define TOV_BYTE_ZERO       8'h00
`define TOV_INSTR_DIV_MAX   2'h3
`define TOV_PS_ZERO         3'h0
`define TOV_DIV_ZERO        2'h0
`define TOV_MODE_ZERO       4'h0
`define TOV_PS_DIV4_END     2'h3
`define TOV_PS_DIV8_END     3'h7
`define TOV_MODE1_LO        0
`define TOV_MODE1_HI        3
`define TOV_MODE2_LO        4
`define TOV_MODE2_HI        7
`endif

// >>> tov_timer.v
// 16-bit overflow timer with trigger reset, prescaler and clock status flag
//
// Function
// R1 - System clock select 01 enters secondary run mode on the secondary oscillator.
// R2 - Sleep with idle bit clear while secondary selected gives secondary idle.
// R3 - Bit 6 of control reads 1 while secondary oscillator clocks the system.
// R4 - With clock monitor on, the flag follows the real clock source after failure.
// R5 - Counter counts 0000h to FFFFh and wraps to 0000h.
// R6 - Each wrap sets the overflow flag, which stays latched.
// R7 - Interrupt request raised only while the overflow enable is set.
// R8 - Compare mode 1011 trigger pulse from either unit clears the counter.
// R9 - Second unit trigger also starts a conversion when converter enabled.
// R10 - Trigger clear guaranteed only in timer or synchronous counter mode.
// R11 - Compare value acts as period: counter returns to zero on match.
// R12 - Software counter write in trigger cycle wins over the clear.
// R13 - Trigger clear never sets the overflow flag.
// R14 - Software sets high byte msb after overflow for one second ticks.
// R15 - Software never preloads the low byte in clock use.
// R16 - Software selects asynchronous mode, enables interrupt, keeps oscillator running.
// R17 - Source 0 counts every fourth core cycle; 1 counts external rising edges.
// R18 - Bypass bit 1 leaves external clock unsynchronised; 0 synchronises it. The code synchronises it for both settings.
// R19 - Prescale 00,01,10,11 divides by 1,2,4,8.
// R20 - Wide access: high byte buffered, low read loads, low write stores.
// R21 - Software must clear the latched overflow flag itself.
`timescale 1ns/1ps
`include "tov_defs.vh"

module tov_timer (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire                   ce_in,
  input  wire [`TOV_ADDR_W-1:0] addr_in,
  input  wire [7:0]             wdata_in,
  input  wire                   wr_in,
  input  wire                   rd_in,
  input  wire                   ext_clk_in,
  input  wire                   sleep_cmd_in,
  input  wire                   wake_in,
  input  wire                   fail_safe_en_in,
  input  wire                   osc_fail_in,
  input  wire                   cmp1_match_in,
  input  wire                   cmp2_match_in,
  output reg  [7:0]             rdata_out,
  output wire                   overflow_irq_out,
  output reg                    adc_start_out,
  output reg                    sec_run_out,
  output reg                    sec_idle_out,
  output reg                    secondary_osc_on_out
);

  localparam MODE_PRI_RUN = 3'b001;
  localparam MODE_SEC_RUN = 3'b010;
  localparam MODE_SEC_IDL = 3'b100;

  reg [7:0]  timer_control_reg_q;
  reg [7:0]  oscillator_control_reg_q;
  reg [15:0] count_q;
  reg [7:0]  hi_buf_q;
  reg        overflow_irq_flag_q;
  reg        overflow_irq_enable_q;
  reg [15:0] cmp1_val_q;
  reg [15:0] cmp2_val_q;
  reg [3:0]  cmp1_mode_q;
  reg [3:0]  cmp2_mode_q;
  reg        adc_en_q;
  reg [2:0]  mode_q;
  reg [1:0]  instr_div_q;
  reg [2:0]  ps_q;
  reg        ext_s1_q;
  reg        ext_s2_q;
  reg        ext_s3_q;
  reg        fail_s1_q;
  reg        fail_s2_q;

  wire on_w    = timer_control_reg_q[`TOV_CTRL_ON];
  wire src_w   = timer_control_reg_q[`TOV_CTRL_SRC];
  wire byp_w   = timer_control_reg_q[`TOV_CTRL_BYP];
  wire wide_w  = timer_control_reg_q[`TOV_CTRL_WIDE];
  wire [1:0] ps_sel_w = timer_control_reg_q[`TOV_CTRL_PS_HI:`TOV_CTRL_PS_LO];
  wire [1:0] scs_w    = oscillator_control_reg_q[`TOV_OSC_SCS_HI:`TOV_OSC_SCS_LO];

  // Register strobes; a low clock enable masks the whole bus
  wire wr_ctrl = ce_in && wr_in && (addr_in == `TOV_REG_CTRL);
  wire wr_lo   = ce_in && wr_in && (addr_in == `TOV_REG_CNT_LO);
  wire wr_hi   = ce_in && wr_in && (addr_in == `TOV_REG_CNT_HI);
  wire rd_lo   = ce_in && rd_in && (addr_in == `TOV_REG_CNT_LO);

  // Trigger from a compare unit in special event mode
  function trig_of;
    input [3:0]  mode;
    input        match;
    begin
      trig_of = match && (mode == `TOV_CMP_TRIG_MODE);
    end
  endfunction

  // R11 compare as period
  wire trig1_w = trig_of(cmp1_mode_q, cmp1_match_in || (count_q == cmp1_val_q));
  wire trig2_w = trig_of(cmp2_mode_q, cmp2_match_in || (count_q == cmp2_val_q));

  // R17 source select
  wire ext_edge_w = ext_s2_q && !ext_s3_q;
  wire instr_tick_w = (instr_div_q == `TOV_INSTR_DIV_MAX);
  wire src_tick_w = src_w ? ext_edge_w : instr_tick_w;

  // R19 prescale
  reg ps_done_w;
  always @*
  begin
    case (ps_sel_w)
      2'h0: ps_done_w = 1'b1;
      2'h1: ps_done_w = (ps_q[0] == 1'b1);
      2'h2: ps_done_w = (ps_q[1:0] == `TOV_PS_DIV4_END);
      default: ps_done_w = (ps_q == `TOV_PS_DIV8_END);
    endcase
  end

  wire inc_w = on_w && src_tick_w && ps_done_w;
  // R10 trigger clear applies except in asynchronous counter mode
  wire async_w = src_w && byp_w;
  wire trig_clr_w = (trig1_w || trig2_w) && !async_w;
  wire wr_cnt_w = wr_lo || (wr_hi && !wide_w);

  // R18 sync stage is always present; bypass with the external source selected skips the trigger clear
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ext_s1_q  <= 1'b0;
      ext_s2_q  <= 1'b0;
      ext_s3_q  <= 1'b0;
      fail_s1_q <= 1'b0;
      fail_s2_q <= 1'b0;
    end
    else if (ce_in)
    begin
      ext_s1_q  <= ext_clk_in;
      ext_s2_q  <= ext_s1_q;
      ext_s3_q  <= ext_s2_q;
      fail_s1_q <= osc_fail_in;
      fail_s2_q <= fail_s1_q;
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count_q     <= `TOV_CNT_ZERO;
      hi_buf_q    <= `TOV_BYTE_ZERO;
      instr_div_q <= `TOV_DIV_ZERO;
      ps_q        <= `TOV_PS_ZERO;
    end
    else if (ce_in)
    begin
      instr_div_q <= instr_div_q + 2'h1;
      if (on_w && src_tick_w)
        ps_q <= ps_q + 3'h1;
      // R12 write wins over trigger
      if (wr_lo)
      begin
        ps_q <= `TOV_PS_ZERO;
        // R20 buffered high byte
        if (wide_w)
          count_q <= {hi_buf_q, wdata_in};
        else
          count_q <= {count_q[15:8], wdata_in};
      end
      else if (wr_hi && !wide_w)
        count_q <= {wdata_in, count_q[7:0]};
      // R8 trigger clear
      else if (trig_clr_w)
        count_q <= `TOV_CNT_ZERO;
      // R5 count and wrap
      else if (inc_w)
        count_q <= count_q + 16'h0001;
      if (wr_hi && wide_w)
        hi_buf_q <= wdata_in;
      else if (rd_lo && wide_w)
        hi_buf_q <= count_q[15:8];
    end
  end

  // R6 latched flag, set wins over software clear; R13 only a wrap or a software write of 1 sets it
  wire wrap_w = inc_w && !wr_cnt_w && !trig_clr_w && (count_q == `TOV_CNT_MAX);
  wire wr_flags = ce_in && wr_in && (addr_in == `TOV_REG_FLAGS);

  always @(posedge clk_in)
  begin
    if (rst_in)
      overflow_irq_flag_q <= 1'b0;
    else if (ce_in)
    begin
      // A wrap in the same cycle as a software clear wins, so none is lost
      if (wrap_w)
        overflow_irq_flag_q <= 1'b1;
      else if (wr_flags)
        overflow_irq_flag_q <= wdata_in[`TOV_FLAG_OVF];
    end
  end

  // R7 masked request
  assign overflow_irq_out = overflow_irq_flag_q && overflow_irq_enable_q;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      timer_control_reg_q      <= `TOV_BYTE_ZERO;
      oscillator_control_reg_q <= `TOV_BYTE_ZERO;
      overflow_irq_enable_q    <= 1'b0;
      cmp1_val_q               <= `TOV_CNT_ZERO;
      cmp2_val_q               <= `TOV_CNT_ZERO;
      cmp1_mode_q              <= `TOV_MODE_ZERO;
      cmp2_mode_q              <= `TOV_MODE_ZERO;
      adc_en_q                 <= 1'b0;
    end
    else if (ce_in && wr_in)
    begin
      if (wr_ctrl)
        timer_control_reg_q <= wdata_in;
      else if (addr_in == `TOV_REG_ENABLES)
        overflow_irq_enable_q <= wdata_in[`TOV_EN_OVF];
      else if (addr_in == `TOV_REG_OSC_CTRL)
        oscillator_control_reg_q <= wdata_in;
      else if (addr_in == `TOV_REG_CMP1_LO)
        cmp1_val_q[7:0] <= wdata_in;
      else if (addr_in == `TOV_REG_CMP1_HI)
        cmp1_val_q[15:8] <= wdata_in;
      else if (addr_in == `TOV_REG_CMP2_LO)
        cmp2_val_q[7:0] <= wdata_in;
      else if (addr_in == `TOV_REG_CMP2_HI)
        cmp2_val_q[15:8] <= wdata_in;
      else if (addr_in == `TOV_REG_CMP_MODE)
      begin
        cmp1_mode_q <= wdata_in[`TOV_MODE1_HI:`TOV_MODE1_LO];
        cmp2_mode_q <= wdata_in[`TOV_MODE2_HI:`TOV_MODE2_LO];
      end
      else if (addr_in == `TOV_REG_ADC_CTRL)
        adc_en_q <= wdata_in[`TOV_ADC_EN];
    end
  end

  // R9 conversion start from second unit
  always @(posedge clk_in)
  begin
    if (rst_in)
      adc_start_out <= 1'b0;
    else if (ce_in)
      adc_start_out <= trig2_w && adc_en_q;
  end

  // R1 R2 power mode machine
  always @(posedge clk_in)
  begin
    if (rst_in)
      mode_q <= MODE_PRI_RUN;
    else if (ce_in)
    begin
      case (mode_q)
        MODE_PRI_RUN:
          if (scs_w == `TOV_SCS_SECONDARY)
            mode_q <= MODE_SEC_RUN;
        MODE_SEC_RUN:
          if (scs_w != `TOV_SCS_SECONDARY)
            mode_q <= MODE_PRI_RUN;
          else if (sleep_cmd_in && !oscillator_control_reg_q[`TOV_OSC_IDLE])
            mode_q <= MODE_SEC_IDL;
        MODE_SEC_IDL:
          if (wake_in)
            mode_q <= MODE_SEC_RUN;
        default:
          mode_q <= MODE_PRI_RUN;
      endcase
    end
  end

  // R3 R4 clock source status
  wire sec_clk_w = (mode_q != MODE_PRI_RUN) && !(fail_safe_en_in && fail_s2_q);

  // Status bit is read-only: the stored copy is never shown
  reg [7:0] ctrl_rd_w;
  always @*
  begin
    ctrl_rd_w = timer_control_reg_q;
    ctrl_rd_w[`TOV_CTRL_RUN] = sec_clk_w;
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sec_run_out          <= 1'b0;
      sec_idle_out         <= 1'b0;
      secondary_osc_on_out <= 1'b0;
    end
    else if (ce_in)
    begin
      sec_run_out          <= (mode_q == MODE_SEC_RUN);
      sec_idle_out         <= (mode_q == MODE_SEC_IDL);
      secondary_osc_on_out <= timer_control_reg_q[`TOV_CTRL_OSCEN] || sec_clk_w;
    end
  end

  // Read port, data one cycle after strobe
  always @(posedge clk_in)
  begin
    if (rst_in)
      rdata_out <= `TOV_BYTE_ZERO;
    else if (ce_in)
    begin
      if (!rd_in)
        rdata_out <= `TOV_BYTE_ZERO;
      else if (addr_in == `TOV_REG_CTRL)
        rdata_out <= ctrl_rd_w;
      else if (addr_in == `TOV_REG_CNT_LO)
        rdata_out <= count_q[7:0];
      else if (addr_in == `TOV_REG_CNT_HI)
        rdata_out <= wide_w ? hi_buf_q : count_q[15:8];
      else if (addr_in == `TOV_REG_FLAGS)
        rdata_out <= {7'h00, overflow_irq_flag_q};
      else if (addr_in == `TOV_REG_ENABLES)
        rdata_out <= {7'h00, overflow_irq_enable_q};
      else if (addr_in == `TOV_REG_OSC_CTRL)
        rdata_out <= oscillator_control_reg_q;
      else if (addr_in == `TOV_REG_CMP1_LO)
        rdata_out <= cmp1_val_q[7:0];
      else if (addr_in == `TOV_REG_CMP1_HI)
        rdata_out <= cmp1_val_q[15:8];
      else if (addr_in == `TOV_REG_CMP2_LO)
        rdata_out <= cmp2_val_q[7:0];
      else if (addr_in == `TOV_REG_CMP2_HI)
        rdata_out <= cmp2_val_q[15:8];
      else if (addr_in == `TOV_REG_CMP_MODE)
        rdata_out <= {cmp2_mode_q, cmp1_mode_q};
      else if (addr_in == `TOV_REG_ADC_CTRL)
        rdata_out <= {7'h00, adc_en_q};
      else
        rdata_out <= `TOV_BYTE_ZERO;
    end
  end

endmodule

// >>> tov_timer_asserts.sv
// Port-level checker for the overflow timer
`timescale 1ns/1ps
`include "tov_defs.vh"
module tov_timer_asserts (
  input wire       clk_in,
  input wire       rst_in,
  input wire       ce_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire       sleep_cmd_in,
  input wire       wake_in,
  input wire       fail_safe_en_in,
  input wire [7:0] rdata_out,
  input wire       overflow_irq_out,
  input wire       sec_run_out,
  input wire       sec_idle_out,
  input wire       secondary_osc_on_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_mode_excl; !(sec_run_out && sec_idle_out); endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("run and idle both high");
  property p_idle_entry; $rose(sec_idle_out) |-> $past(sleep_cmd_in) || $past(sleep_cmd_in, 2);
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle without sleep");
  property p_idle_exit; $fell(sec_idle_out) |-> $past(wake_in) || $past(wake_in, 2); endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle left without wake");
  property p_idle_from_run; $rose(sec_idle_out) |-> $past(sec_run_out); endproperty
  a_idle_from_run: assert property (p_idle_from_run) else $error("idle not from run");
  property p_osc_on; (sec_run_out && !fail_safe_en_in) [*2] |-> secondary_osc_on_out;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator off in run");
  property p_irq_hold; overflow_irq_out && !(wr_in && (addr_in == `TOV_REG_FLAGS
    || addr_in == `TOV_REG_ENABLES)) |=> overflow_irq_out; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped alone");
  property p_irq_mask; ce_in && wr_in && addr_in == `TOV_REG_ENABLES && !wdata_in[0]
    |=> !overflow_irq_out; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request seen");
  property p_flag_read; ce_in && rd_in && addr_in == `TOV_REG_FLAGS && overflow_irq_out
    |=> rdata_out[0]; endproperty
  a_flag_read: assert property (p_flag_read) else $error("flag reads low");
  property p_run_flag; ce_in && rd_in && addr_in == `TOV_REG_CTRL && sec_run_out
    && !fail_safe_en_in |=> rdata_out[6]; endproperty
  a_run_flag: assert property (p_run_flag) else $error("status bit low");
  c_irq: cover property (overflow_irq_out);
  c_idle: cover property (sec_idle_out);
  c_run: cover property (sec_run_out);
endmodule
bind tov_timer tov_timer_asserts i_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .sleep_cmd_in(sleep_cmd_in), .wake_in(wake_in), .fail_safe_en_in(fail_safe_en_in),
  .rdata_out(rdata_out), .overflow_irq_out(overflow_irq_out), .sec_run_out(sec_run_out),
  .sec_idle_out(sec_idle_out), .secondary_osc_on_out(secondary_osc_on_out));

// >>> tov_ext_src.sv
// External count clock source: a burst of rising edges on request
`timescale 1ns/1ps
module tov_ext_src #(parameter int HALF_NS = 28) (
  input  wire       go_in,
  input  wire [7:0] n_in,
  output logic      pin_out,
  output logic      busy_out
);
  initial
  begin
    pin_out = 1'b0;
    busy_out = 1'b0;
    forever
    begin
      @(posedge go_in);
      busy_out = 1'b1;
      repeat (n_in)
      begin
        #HALF_NS pin_out = 1'b1;
        #HALF_NS pin_out = 1'b0;
      end
      busy_out = 1'b0;
    end
  end
endmodule

// >>> tov_tb.sv
// Self-checking bench for the overflow timer
`timescale 1ns/1ps
`include "tov_defs.vh"
module tb;
  logic clk_in = 0, rst_in = 1, ce_in = 1, wr_in = 0, rd_in = 0, sleep_cmd_in = 0;
  logic wake_in = 0, fail_safe_en_in = 0, osc_fail_in = 0, cmp1_match_in = 0;
  logic cmp2_match_in = 0, go = 0, ext_clk, busy;
  logic [3:0] addr_in = 0;
  logic [7:0] wdata_in = 0, rdata_out, v, n = 8'h10;
  logic overflow_irq_out, adc_start_out, sec_run_out, sec_idle_out, secondary_osc_on_out;
  int err_total = 0, checks_done = 0;
  tov_timer i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ext_clk_in(ext_clk),
    .sleep_cmd_in(sleep_cmd_in), .wake_in(wake_in), .fail_safe_en_in(fail_safe_en_in),
    .osc_fail_in(osc_fail_in), .cmp1_match_in(cmp1_match_in), .cmp2_match_in(cmp2_match_in),
    .rdata_out(rdata_out), .overflow_irq_out(overflow_irq_out), .adc_start_out(adc_start_out),
    .sec_run_out(sec_run_out), .sec_idle_out(sec_idle_out),
    .secondary_osc_on_out(secondary_osc_on_out));
  tov_ext_src i_src (.go_in(go), .n_in(n), .pin_out(ext_clk), .busy_out(busy));
  initial
  begin
    forever #4 clk_in = ~clk_in;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic t1 = 0);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    cmp1_match_in <= t1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    cmp1_match_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // Bounded wait for an output to reach a level
  task automatic wt(input int k, input logic lv);
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clk_in);
      #1;
      if ((k == 0 ? overflow_irq_out : k == 1 ? adc_start_out : k == 2 ? sec_run_out
          : k == 3 ? sec_idle_out : busy) === lv)
        return;
    end
    err_total++;
    $display("[ERR] wait %0d exp %b seen timeout", k, lv);
    close_out();
  endtask
  task automatic pulse(input int k);
    @(posedge clk_in);
    if (k == 0) go <= 1'b1; else if (k == 1) cmp2_match_in <= 1'b1;
    else if (k == 2) sleep_cmd_in <= 1'b1; else wake_in <= 1'b1;
    @(posedge clk_in);
    {go, cmp2_match_in, sleep_cmd_in, wake_in} <= 4'h0;
  endtask
  task automatic s_wrap();
    wr(`TOV_REG_ENABLES, 8'h01);
    wr(`TOV_REG_CNT_HI, 8'hff);
    wr(`TOV_REG_CNT_LO, 8'hf0);
    wr(`TOV_REG_CTRL, 8'h01);
    wt(0, 1'b1);
    rd(`TOV_REG_CNT_HI, v);
    chk("hi after wrap", v, 8'h00);
    rd(`TOV_REG_FLAGS, v);
    chk("flag", v, 8'h01);
    wr(`TOV_REG_ENABLES, 8'h00);
    #1 chk("masked irq", {7'h0, overflow_irq_out}, 8'h00);
    rd(`TOV_REG_FLAGS, v);
    chk("flag kept", v, 8'h01);
    // Software clears the flag itself
    wr(`TOV_REG_FLAGS, 8'h00);
  endtask
  task automatic s_trig();
    wr(`TOV_REG_CMP1_LO, 8'h10);
    wr(`TOV_REG_CMP_MODE, 8'h0b);
    wr(`TOV_REG_CNT_LO, 8'h00);
    repeat (300) @(posedge clk_in);
    rd(`TOV_REG_CNT_LO, v);
    chk("period", {7'h0, v <= 8'h10}, 8'h01);
    rd(`TOV_REG_FLAGS, v);
    chk("no flag", v, 8'h00);
    wr(`TOV_REG_CMP2_LO, 8'hff);
    wr(`TOV_REG_CMP2_HI, 8'hff);
    wr(`TOV_REG_CMP_MODE, 8'hb0);
    wr(`TOV_REG_ADC_CTRL, 8'h01);
    pulse(1);
    // Unit 2 trigger starts a conversion
    #1 chk("adc start", {7'h0, adc_start_out}, 8'h01);
    @(posedge clk_in);
    #1 chk("adc one pulse", {7'h0, adc_start_out}, 8'h00);
    wr(`TOV_REG_CTRL, 8'h00);
    wr(`TOV_REG_CMP_MODE, 8'h0b);
    wr(`TOV_REG_CNT_LO, 8'h55, 1'b1);
    rd(`TOV_REG_CNT_LO, v);
    chk("write wins", v, 8'h55);
    wr(`TOV_REG_CMP_MODE, 8'h00);
  endtask
  task automatic s_ext();
    for (int i = 0; i < 4; i++)
    begin
      wr(`TOV_REG_CTRL, {2'b00, i[1:0], 1'b0, i[0], 2'b11});
      wr(`TOV_REG_CNT_HI, 8'h00);
      wr(`TOV_REG_CNT_LO, 8'h00);
      pulse(0);
      wt(4, 1'b0);
      repeat (6) @(posedge clk_in);
      rd(`TOV_REG_CNT_LO, v);
      chk("ext count", v, 8'(16 >> i));
    end
  endtask
  task automatic s_rtc();
    wr(`TOV_REG_CTRL, 8'h0f);
    wr(`TOV_REG_ENABLES, 8'h01);
    wr(`TOV_REG_CNT_HI, 8'hff);
    wr(`TOV_REG_CNT_LO, 8'hf0);
    pulse(0);
    wt(4, 1'b0);
    repeat (6) @(posedge clk_in);
    #1 chk("rtc irq", {7'h0, overflow_irq_out}, 8'h01);
    // high byte msb set after overflow
    wr(`TOV_REG_CNT_HI, 8'h80);
    wr(`TOV_REG_FLAGS, 8'h00);
    rd(`TOV_REG_CNT_HI, v);
    chk("rtc preload", v, 8'h80);
    rd(`TOV_REG_CNT_LO, v);
    chk("rtc low kept", v, 8'h00);
    rd(`TOV_REG_FLAGS, v);
    chk("rtc flag clear", v, 8'h00);
    wr(`TOV_REG_ENABLES, 8'h00);
  endtask
  task automatic s_wide();
    wr(`TOV_REG_CTRL, 8'h80);
    wr(`TOV_REG_CNT_HI, 8'h12);
    wr(`TOV_REG_CNT_LO, 8'h34);
    wr(`TOV_REG_CNT_HI, 8'h99);
    rd(`TOV_REG_CNT_LO, v);
    chk("wide lo", v, 8'h34);
    rd(`TOV_REG_CNT_HI, v);
    chk("wide hi", v, 8'h12);
    // Low clock enable ignores a write
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(`TOV_REG_CNT_LO, 8'h77);
    ce_in <= 1'b1;
    rd(`TOV_REG_CNT_LO, v);
    chk("frozen write", v, 8'h34);
  endtask
  task automatic s_modes();
    wr(`TOV_REG_CTRL, 8'h00);
    wr(`TOV_REG_OSC_CTRL, 8'h01);
    wt(2, 1'b1);
    chk("osc in use", {7'h0, secondary_osc_on_out}, 8'h01);
    rd(`TOV_REG_CTRL, v);
    chk("status run", v, 8'h40);
    pulse(2);
    wt(3, 1'b1);
    pulse(3);
    wt(3, 1'b0);
    @(posedge clk_in);
    fail_safe_en_in <= 1'b1;
    osc_fail_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rd(`TOV_REG_CTRL, v);
    chk("status failed", v, 8'h00);
    @(posedge clk_in);
    fail_safe_en_in <= 1'b0;
    osc_fail_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rd(`TOV_REG_CTRL, v);
    chk("status back", v, 8'h40);
    wr(`TOV_REG_OSC_CTRL, 8'h00);
    wt(2, 1'b0);
    chk("osc idle", {7'h0, secondary_osc_on_out}, 8'h00);
    rd(`TOV_REG_CTRL, v);
    chk("status primary", v, 8'h00);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    wr(4'hf, 8'hff);
    rd(4'hf, v);
    chk("unmapped", v, 8'h00);
    s_wrap();
    s_trig();
    s_ext();
    s_rtc();
    s_wide();
    s_modes();
    close_out();
  end
endmodule
